// file: src/supervisor_cfg.svh
// Timing and output polarity constants for the supply supervisor reset logic
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
`define CLK_HZ 40000000
`define HOLD_SHORT_MS 10
`define HOLD_LONG_MS 200
`define HOLD_SHORT_CYC ((`CLK_HZ / 1000) * `HOLD_SHORT_MS)
`define HOLD_LONG_CYC ((`CLK_HZ / 1000) * `HOLD_LONG_MS)
`define RESET_ACTIVE_HIGH 1'b0
`endif

// file: src/supervisor_pkg.sv
// Types for the supply supervisor reset logic
package supervisor_pkg;
    typedef enum logic [2:0] {
        ST_ASSERT = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } sup_state_e;
    typedef logic [23:0] hold_count_t;
endpackage : supervisor_pkg

// file: src/hold_timer.sv
// Down counter that times the reset hold delay
`timescale 1ns/100ps
`default_nettype none
module hold_timer #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_value,
    // Status
    output logic done
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    assign count_next = load ? load_value :
        (count_reg != '0) ? count_reg - {{(W-1){1'b0}}, 1'b1} : count_reg;
    assign done = (count_reg == '0) && !load;
    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule : hold_timer
`default_nettype wire

// file: src/supply_supervisor_reset_logic.sv
// Reset generation logic of a supply voltage supervisor
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_cfg.svh"
module supply_supervisor_reset_logic
    import supervisor_pkg::*;
#(
    parameter int HOLD_SHORT = `HOLD_SHORT_CYC,
    parameter int HOLD_LONG = `HOLD_LONG_CYC,
    parameter bit ACTIVE_HIGH = `RESET_ACTIVE_HIGH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Comparator results and pins
    input wire logic above_upper_threshold,
    input wire logic below_lower_threshold,
    input wire logic manual_trigger_n,
    input wire logic delay_select,
    // Reset output
    output logic sys_reset_out
);
    sup_state_e state_reg;
    sup_state_e state_next;
    logic cause;
    logic load;
    logic done;
    logic [23:0] hold_value;
    logic rst_active_reg;
    logic rst_active_next;

    // Undervoltage latches until the upper threshold is passed (hysteresis)
    logic uv_reg;
    logic uv_next;
    assign uv_next = below_lower_threshold ? 1'b1 :
        (above_upper_threshold ? 1'b0 : uv_reg);
    assign cause = uv_next || !manual_trigger_n;
    assign hold_value = delay_select ? 24'(HOLD_LONG) : 24'(HOLD_SHORT);
    // Timer reloads while a cause stands and on the first quiet edge,
    // so a reset release with no cause still waits out the full delay
    assign load = cause || (state_reg == ST_ASSERT);

    hold_timer #(.W(24)) u_timer (
        .clk(clk),
        .reset(reset),
        .load(load),
        .load_value(hold_value),
        .done(done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ASSERT: begin
                if (!cause) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cause) begin
                    state_next = ST_ASSERT;
                end else if (done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cause) begin
                    state_next = ST_ASSERT;
                end
            end
            default: state_next = ST_ASSERT;
        endcase
    end

    // Active while a cause stands or the delay has not yet run out
    assign rst_active_next = cause || (state_next != ST_RUN);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_ASSERT;
            uv_reg <= 1'b1;
            rst_active_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            uv_reg <= uv_next;
            rst_active_reg <= rst_active_next;
        end
    end

    // Polarity fixed at build time; one pin only
    logic out_level_next;
    assign out_level_next = ACTIVE_HIGH ? rst_active_next : !rst_active_next;
    always_ff @(posedge clk) begin
        if (reset) begin
            sys_reset_out <= ACTIVE_HIGH;
        end else begin
            sys_reset_out <= out_level_next;
        end
    end

    // Checker helper: cycles since the last cause, saturating
    localparam int QUIET_W = 25;
    logic [QUIET_W-1:0] quiet_cnt_reg;
    logic [QUIET_W-1:0] quiet_cnt_next;
    logic [QUIET_W-1:0] hold_expect;
    logic quiet_sat;
    assign quiet_sat = &quiet_cnt_reg;
    assign quiet_cnt_next = cause ? '0 :
        (quiet_sat ? quiet_cnt_reg : quiet_cnt_reg + {{(QUIET_W-1){1'b0}}, 1'b1});
    // Quiet count at which the output is first seen inactive
    assign hold_expect = delay_select ? QUIET_W'(HOLD_LONG + 2) : QUIET_W'(HOLD_SHORT + 2);
    always_ff @(posedge clk) begin
        if (reset) begin
            quiet_cnt_reg <= '0;
        end else begin
            quiet_cnt_reg <= quiet_cnt_next;
        end
    end

    property p_manual_asserts;
        @(posedge clk) disable iff (reset)
        !manual_trigger_n |=> rst_active_reg;
    endproperty
    a_manual_asserts: assert property (p_manual_asserts) else $error("manual low no reset");

    property p_uv_asserts;
        @(posedge clk) disable iff (reset)
        below_lower_threshold |=> rst_active_reg;
    endproperty
    a_uv_asserts: assert property (p_uv_asserts) else $error("undervoltage no reset");

    property p_polarity;
        @(posedge clk) disable iff (reset)
        ##1 (sys_reset_out == (ACTIVE_HIGH ? rst_active_reg : !rst_active_reg));
    endproperty
    a_polarity: assert property (p_polarity) else $error("output polarity wrong");

    sequence s_cause_clears;
        cause ##1 !cause;
    endsequence
    property p_hold_after_clear;
        @(posedge clk) disable iff (reset)
        s_cause_clears |-> rst_active_reg ##1 rst_active_reg;
    endproperty
    a_hold_after_clear: assert property (p_hold_after_clear) else $error("released early");

    property p_release_needs_done;
        @(posedge clk) disable iff (reset)
        $fell(rst_active_reg) |-> $past(state_reg) == ST_HOLD && $past(done);
    endproperty
    a_release_needs_done: assert property (p_release_needs_done) else $error("release w/o delay");

    property p_restart;
        @(posedge clk) disable iff (reset)
        (state_reg == ST_HOLD && cause) |=> state_reg == ST_ASSERT;
    endproperty
    a_restart: assert property (p_restart) else $error("delay not restarted");

    property p_or;
        @(posedge clk) disable iff (reset)
        (state_reg == ST_RUN && !cause) |=> !rst_active_reg;
    endproperty
    a_or: assert property (p_or) else $error("reset with no cause");

    property p_select;
        @(posedge clk) disable iff (reset)
        $fell(rst_active_reg) |-> quiet_cnt_reg == hold_expect;
    endproperty
    a_select: assert property (p_select) else $error("delay select wrong");

    property p_reset_active;
        @(posedge clk)
        reset |=> rst_active_reg && (sys_reset_out == ACTIVE_HIGH);
    endproperty
    a_reset_active: assert property (p_reset_active) else $error("reset not active");

    property p_hold_full;
        @(posedge clk) disable iff (reset)
        (quiet_cnt_reg < hold_expect) |-> rst_active_reg;
    endproperty
    a_hold_full: assert property (p_hold_full) else $error("hold delay cut short");

    property p_release_exact;
        @(posedge clk) disable iff (reset)
        (quiet_cnt_reg >= hold_expect) |-> !rst_active_reg;
    endproperty
    a_release_exact: assert property (p_release_exact) else $error("release late");

    property p_state_onehot;
        @(posedge clk) disable iff (reset)
        $onehot(state_reg);
    endproperty
    a_state_onehot: assert property (p_state_onehot) else $error("state not one-hot");

    sequence s_manual_lift;
        !manual_trigger_n ##1 manual_trigger_n;
    endsequence
    property p_manual_release;
        @(posedge clk) disable iff (reset)
        s_manual_lift |-> rst_active_reg ##1 rst_active_reg;
    endproperty
    a_manual_release: assert property (p_manual_release) else $error("manual early release");

    property p_uv_holds;
        @(posedge clk) disable iff (reset)
        uv_reg |-> rst_active_reg;
    endproperty
    a_uv_holds: assert property (p_uv_holds) else $error("released in undervoltage");

    sequence s_hold_hit;
        (state_reg == ST_HOLD && !cause) ##1 cause;
    endsequence
    property p_restart_holds;
        @(posedge clk) disable iff (reset)
        s_hold_hit |=> rst_active_reg ##1 rst_active_reg;
    endproperty
    a_restart_holds: assert property (p_restart_holds) else $error("gap on restart");
endmodule : supply_supervisor_reset_logic
`default_nettype wire

// file: test/reset_sink_model.sv
// Reset input of the logic fed by the supervisor
`timescale 1ns/100ps
`default_nettype none
module reset_sink_model (
    // Clock and reset input
    input wire logic clk,
    input wire logic rst_n,
    // Boots seen
    output int boots
);
    logic run_reg = 1'b0;
    int boot_count = 0;
    assign boots = boot_count;
    // One input, active low only
    always @(posedge clk) begin
        if (rst_n === 1'b1 && !run_reg) begin
            boot_count <= boot_count + 1;
        end
        run_reg <= (rst_n === 1'b1);
    end
endmodule : reset_sink_model
`default_nettype wire

// file: test/supply_supervisor_reset_logic_tb_top.sv
// Self-checking bench for the supply supervisor reset logic
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_reset_logic_tb_top;
    localparam int HS = 20;
    localparam int HL = 50;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic up = 1'b0, lo = 1'b1, mt_n = 1'b1, sel = 1'b0;
    logic rst_out;
    int num_errors = 0, samples_checked = 0, cyc = 0, cnt = 0, seed = 86, boots;
    bit uv = 1'b1;
    bit exp_prev = 1'b0;
    int exp_boots = 0;
    supply_supervisor_reset_logic #(.HOLD_SHORT(HS), .HOLD_LONG(HL), .ACTIVE_HIGH(1'b0)) dut (
        .clk(clk), .reset(reset), .above_upper_threshold(up), .below_lower_threshold(lo),
        .manual_trigger_n(mt_n), .delay_select(sel), .sys_reset_out(rst_out));
    reset_sink_model sink (.clk(clk), .rst_n(rst_out), .boots(boots));
    initial forever #12.5 clk = ~clk;
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic exp);
        samples_checked++;
        if (rst_out !== exp) begin
            num_errors++;
            $display("unexpected sys_reset_out: expected %b seen %b", exp, rst_out);
        end
    endtask : chk
    task automatic drive(input logic u, l, m, input int n);
        up = u;
        lo = l;
        mt_n = m;
        repeat (n) @(negedge clk);
    endtask : drive
    // Model: latch with hysteresis, count of quiet edges; the first quiet edge
    // loads the delay, so release shows once the count passes hold plus one
    always @(posedge clk) begin
        int hold;
        bit exp_lvl;
        hold = sel ? HL : HS;
        cyc++;
        if (reset) begin
            uv = 1'b1;
            cnt = 0;
        end else begin
            if (lo) uv = 1'b1;
            else if (up) uv = 1'b0;
            cnt = (uv || !mt_n) ? 0 : cnt + 1;
        end
        #1;
        exp_lvl = (cnt > hold + 1);
        chk(exp_lvl);
        if (exp_lvl && !exp_prev) begin
            exp_boots++;
        end
        exp_prev = exp_lvl;
        if (cyc > 4000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        int r;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        drive(1'b0, 1'b1, 1'b1, 5);
        drive(1'b1, 1'b0, 1'b1, HS + 10);
        $display("test power-up done");
        drive(1'b1, 1'b0, 1'b0, 3);
        drive(1'b1, 1'b0, 1'b1, HS / 2);
        drive(1'b1, 1'b1, 1'b1, 1);
        drive(1'b0, 1'b0, 1'b1, HS + 10);
        drive(1'b1, 1'b0, 1'b1, HS + 10);
        $display("test manual and restart done");
        drive(1'b1, 1'b0, 1'b0, 2);
        sel = 1'b1;
        drive(1'b1, 1'b0, 1'b1, HL + 10);
        sel = 1'b0;
        $display("test long hold done");
        // Causes kept rare so releases still happen
        repeat (60) begin
            r = $random(seed);
            drive(r[0] | r[1], r[2] & r[3] & r[4], !(r[5] & r[6] & r[7]), (r[13:8] % 40) + 1);
        end
        $display("test random done");
        reset = 1'b1;
        drive(1'b1, 1'b0, 1'b1, 3);
        reset = 1'b0;
        drive(1'b1, 1'b0, 1'b1, HS + 10);
        $display("test second reset done");
        samples_checked++;
        if (boots != exp_boots) begin
            num_errors++;
            $display("unexpected boots: expected %0d seen %0d", exp_boots, boots);
        end
        print_verdict();
    end
endmodule : supply_supervisor_reset_logic_tb_top
`default_nettype wire
